// file: logic/organ_pkg.sv
package organ_pkg;

    // Combination storage sizes
    localparam int STOP_W  = 16;
    localparam int N_STEPS = 60;
    localparam int STEP_W  = 6;
    localparam int N_PROG  = 2;
    localparam int MEM_AW  = 7;
    localparam int N_SFZ   = 2;
    localparam int N_VENT  = 2;
    localparam int N_GEN   = 4;
    localparam int N_LEVEL = 4;
    localparam int LEVEL_W = 2;
    localparam int TPOS_W  = 4;

    // Pipe driver board sizes
    localparam int NOTE_W      = 7;
    localparam int NOTES_SMALL = 49;
    localparam int NOTES_MID   = 73;
    localparam int NOTES_MAX   = 97;
    localparam int N_LINE      = 7;

    // Timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int ERASE_S        = 12;
    localparam int STEADY_MS      = 20;
    localparam int ERASE_STEP_CYC = ERASE_S * (CLK_HZ / N_STEPS);
    localparam int STEADY_CYC     = STEADY_MS * (CLK_HZ / 1000);
    localparam int CNT_W          = 32;

    // Register map and fields
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_LINE   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_NOTE   = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_COMBO  = 12'h00C;
    localparam int ST_MODE   = 0;
    localparam int ST_PROG   = 1;
    localparam int ST_ERASE  = 2;
    localparam int ST_STEADY = 3;
    localparam int ST_STEP   = 8;
    localparam int NOTE_ON   = 8;

    typedef struct packed {
        logic                   cresSw;
        logic                   clearSw;
        logic                   midiSw;
        logic                   couplerSw;
        logic                   storeBtn;
        logic                   cresSel;
        logic                   setPiston;
        logic [N_SFZ-1:0]       sfz;
        logic [N_VENT-1:0]      ventil;
        logic [N_GEN-1:0]       general;
        logic [LEVEL_W-1:0]     level;
        logic                   transpAct;
        logic [TPOS_W-1:0]      transpPos;
        logic [STEP_W-1:0]      shoe;
        logic [STOP_W-1:0]      stops;
    } console_in_s;

    typedef struct packed {
        logic                   active;
        logic [TPOS_W-1:0]      pos;
        logic [STOP_W-1:0]      stops;
    } general_s;

    typedef enum {ER_IDLE, ER_ARMED, ER_RUN} erase_e;

    // Shoe position clamped to the last step
    function automatic logic [STEP_W-1:0] satStep(input logic [STEP_W-1:0] shoe);
        return (shoe >= STEP_W'(N_STEPS)) ? STEP_W'(N_STEPS - 1) : shoe;
    endfunction

    // Flat crescendo memory address of one program step
    function automatic logic [MEM_AW-1:0] memAddr(input logic prog, input logic [STEP_W-1:0] step);
        return (prog ? MEM_AW'(N_STEPS) : MEM_AW'(0)) + MEM_AW'(step);
    endfunction

endpackage

// file: logic/input_sync.sv
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // Pins in, synchronised out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// file: logic/note_driver.sv
`timescale 1ns/1ps
module note_driver #(
    parameter int BOARD_NOTES = organ_pkg::NOTES_MAX
) (
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rstn,
    // Note and stop line writes
    input  wire logic                              noteWr,
    input  wire logic [organ_pkg::NOTE_W-1:0]      noteIdx,
    input  wire logic                              noteOn,
    input  wire logic                              lineWr,
    input  wire logic [organ_pkg::N_LINE-1:0]      lineData,
    // Driver outputs
    output logic      [organ_pkg::NOTES_MAX-1:0]   noteOut,
    output logic      [organ_pkg::N_LINE-1:0]      stopLineOut
);

    // Notes past the board size are dropped, never wrapped
    wire inRange = noteIdx < organ_pkg::NOTE_W'(BOARD_NOTES); // [R17]

    // Index 0 is the lowest note, on the first output
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            noteOut     <= '0;
            stopLineOut <= '0;
        end else begin
            if (noteWr && inRange) begin
                noteOut[noteIdx] <= noteOn; // [R15]
            end
            if (lineWr) begin
                stopLineOut <= lineData; // [R16]
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_board_limit;
        (noteWr && !inRange) |=> (noteOut == $past(noteOut));
    endproperty
    a_board_limit: assert property (p_board_limit) else $error("note beyond board size changed outputs"); // [R17]

endmodule

// file: logic/crescendo_step_programmer.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// What this block does
// R1: Program one is active after power-up
// R2: Reversible piston toggles programs, kept separately
// R3: Mode shows current step on six lamps
// R4: Lamp weights 32 16 8 4 2 1
// R5: Mode needs program on, other switches off
// R6: Clear switch plus store erases, about 12s
// R7: Shoe picks step, must be steady first
// R8: Store records current stops at step
// R9: Program switch off: stored steps play normally
// R10: Switch numbers are sums of binary weights
// R11: Set plus sforzando stores, completes on release
// R12: Set plus ventil stores the current stops
// R13: General set also stores transposer per level
// R14: Second console chains serial data to chamber (not implemented: this block has no serial chain port)
// R15: Driver outputs follow ascending note pitch
// R16: Seven programmable stop line outputs per board
// R17: Boards hold at most 49, 73, 97 notes
// R18: Shoe step saturates at step sixty
module crescendo_step_programmer #(
    parameter int ERASE_STEP_CYC = organ_pkg::ERASE_STEP_CYC,
    parameter int STEADY_CYC     = organ_pkg::STEADY_CYC,
    parameter int BOARD_NOTES    = organ_pkg::NOTES_MAX
) (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                rstn,
    // APB slave
    input  wire logic [organ_pkg::ADDR_W-1:0]        paddr,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // Console switches, pistons, shoe and stops
    input  wire organ_pkg::console_in_s              consoleIn,
    // Console outputs
    output logic      [organ_pkg::STEP_W-1:0]        stepLamps,
    output logic      [organ_pkg::STOP_W-1:0]        stopsOut,
    output logic      [organ_pkg::TPOS_W-1:0]        transpPos,
    output logic                                     transpAct,
    // Pipe driver board
    output logic      [organ_pkg::NOTES_MAX-1:0]     noteOut,
    output logic      [organ_pkg::N_LINE-1:0]        stopLineOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Input capture and edges
    organ_pkg::console_in_s ci;
    organ_pkg::console_in_s prev_r;

    input_sync #(.W($bits(organ_pkg::console_in_s))) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (consoleIn),
        .dout    (ci)
    );

    // Previous sample for press detection
    always_ff @(posedge clk_sys) begin
        if (!rstn) prev_r <= '0;
        else       prev_r <= ci;
    end

    wire                          storeRise = ci.storeBtn & ~prev_r.storeBtn;
    wire                          selRise   = ci.cresSel & ~prev_r.cresSel;
    wire [organ_pkg::N_SFZ-1:0]   sfzRise   = ci.sfz & ~prev_r.sfz;
    wire [organ_pkg::N_VENT-1:0]  ventRise  = ci.ventil & ~prev_r.ventil;
    wire [organ_pkg::N_GEN-1:0]   genRise   = ci.general & ~prev_r.general;
    wire                          anyRise   = |{sfzRise, ventRise, genRise};
    wire                          anyHeld   = |{ci.sfz, ci.ventil, ci.general};

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and step
    // Any other program switch on blocks the mode
    wire otherOff = ~ci.midiSw & ~ci.couplerSw;
    wire cresMode = ci.cresSw & otherOff & ~ci.clearSw; // [R5]
    wire clrMode  = ci.cresSw & otherOff & ci.clearSw;
    wire [organ_pkg::STEP_W-1:0] stepIdx = organ_pkg::satStep(ci.shoe); // [R18]
    wire [organ_pkg::STEP_W-1:0] stepNum = stepIdx + organ_pkg::STEP_W'(1);
    logic                         progSel_r;
    logic [organ_pkg::STEP_W-1:0] stepPrev_r;
    logic [organ_pkg::CNT_W-1:0]  steadyCnt_r;
    wire                          steady = steadyCnt_r == organ_pkg::CNT_W'(STEADY_CYC);

    // Program select and shoe settling; a moving shoe restarts the wait
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            progSel_r   <= 1'b0; // [R1]
            stepPrev_r  <= '0;
            steadyCnt_r <= '0;
        end else begin
            if (selRise) progSel_r <= ~progSel_r; // [R2]
            stepPrev_r <= stepIdx;
            if (stepIdx != stepPrev_r)  steadyCnt_r <= '0; // [R7]
            else if (!steady)           steadyCnt_r <= steadyCnt_r + organ_pkg::CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crescendo memory, store and erase
    logic [organ_pkg::STOP_W-1:0] cresMem [organ_pkg::N_PROG*organ_pkg::N_STEPS];
    organ_pkg::erase_e            erState_r;
    logic                         eraseProg_r;
    logic [organ_pkg::STEP_W-1:0] eraseIdx_r;
    logic [organ_pkg::CNT_W-1:0]  eraseCnt_r;

    wire eraseTick = (erState_r == organ_pkg::ER_RUN)
                   && (eraseCnt_r == organ_pkg::CNT_W'(ERASE_STEP_CYC - 1));
    wire storeOk   = storeRise && cresMode && steady && (erState_r == organ_pkg::ER_IDLE); // [R7]
    wire lastErase = eraseIdx_r == organ_pkg::STEP_W'(organ_pkg::N_STEPS - 1);

    // One write port shared by store and erase
    wire                          wrEn   = storeOk | eraseTick;
    wire [organ_pkg::MEM_AW-1:0]  wrAddr = eraseTick ? organ_pkg::memAddr(eraseProg_r, eraseIdx_r)
                                                     : organ_pkg::memAddr(progSel_r, stepIdx);
    wire [organ_pkg::STOP_W-1:0]  wrData = eraseTick ? '0 : ci.stops; // [R8]
    wire [organ_pkg::STOP_W-1:0]  memRd  = cresMem[organ_pkg::memAddr(progSel_r, stepIdx)];

    // Contents are not reset; an organ keeps its programs
    always_ff @(posedge clk_sys) begin
        if (wrEn) cresMem[wrAddr] <= wrData; // [R8]
    end

    // Erase is armed by store, runs once the clear switch is off
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            erState_r   <= organ_pkg::ER_IDLE;
            eraseProg_r <= 1'b0;
            eraseIdx_r  <= '0;
            eraseCnt_r  <= '0;
        end else begin
            unique case (erState_r)
                organ_pkg::ER_IDLE: begin
                    if (storeRise && clrMode) begin
                        erState_r   <= organ_pkg::ER_ARMED; // [R6]
                        eraseProg_r <= progSel_r;
                    end
                end
                organ_pkg::ER_ARMED: begin
                    if (!ci.clearSw) begin
                        erState_r  <= organ_pkg::ER_RUN; // [R6]
                        eraseIdx_r <= '0;
                        eraseCnt_r <= '0;
                    end
                end
                organ_pkg::ER_RUN: begin
                    eraseCnt_r <= eraseTick ? '0 : eraseCnt_r + organ_pkg::CNT_W'(1);
                    if (eraseTick) begin
                        eraseIdx_r <= eraseIdx_r + organ_pkg::STEP_W'(1);
                        if (lastErase) erState_r <= organ_pkg::ER_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Set piston captures for sforzando, ventil and generals
    logic [organ_pkg::STOP_W-1:0] sfzMem_r  [organ_pkg::N_SFZ];
    logic [organ_pkg::STOP_W-1:0] ventMem_r [organ_pkg::N_VENT];
    organ_pkg::general_s          genMem_r  [organ_pkg::N_LEVEL*organ_pkg::N_GEN];
    logic                         setPend_r;
    logic [organ_pkg::N_SFZ-1:0]  capSfz_r;
    logic [organ_pkg::N_VENT-1:0] capVent_r;
    logic [organ_pkg::N_GEN-1:0]  capGen_r;
    logic [organ_pkg::LEVEL_W-1:0] capLevel_r;
    organ_pkg::general_s          capVal_r;
    logic [organ_pkg::N_SFZ-1:0]  sfzOn_r;
    logic [organ_pkg::N_VENT-1:0] ventOn_r;

    wire capture = ci.setPiston && anyRise && !setPend_r;
    wire commit  = setPend_r && !ci.setPiston && !anyHeld; // [R11]

    // Pressed general and the sforzando and ventil sums
    logic                         genHit;
    int                           genSel;
    logic [organ_pkg::STOP_W-1:0] sfzOr;
    logic [organ_pkg::STOP_W-1:0] ventOr;
    always_comb begin
        genHit = 1'b0;
        genSel = 0;
        sfzOr  = '0;
        ventOr = '0;
        for (int g = organ_pkg::N_GEN - 1; g >= 0; g--) begin
            if (genRise[g]) begin
                genHit = 1'b1;
                genSel = ci.level * organ_pkg::N_GEN + g;
            end
        end
        for (int i = 0; i < organ_pkg::N_SFZ; i++) begin
            if (sfzOn_r[i]) sfzOr = sfzOr | sfzMem_r[i];
        end
        for (int i = 0; i < organ_pkg::N_VENT; i++) begin
            if (ventOn_r[i]) ventOr = ventOr | ventMem_r[i];
        end
    end

    // Stops are caught at the press; the memory is written on release
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            setPend_r  <= 1'b0;
            capSfz_r   <= '0;
            capVent_r  <= '0;
            capGen_r   <= '0;
            capLevel_r <= '0;
            capVal_r   <= '0;
            sfzOn_r    <= '0;
            ventOn_r   <= '0;
            for (int i = 0; i < organ_pkg::N_SFZ; i++) sfzMem_r[i] <= '0;
            for (int i = 0; i < organ_pkg::N_VENT; i++) ventMem_r[i] <= '0;
            for (int i = 0; i < organ_pkg::N_LEVEL*organ_pkg::N_GEN; i++) genMem_r[i] <= '0;
        end else if (capture) begin
            setPend_r  <= 1'b1;
            capSfz_r   <= sfzRise;
            capVent_r  <= ventRise;
            capGen_r   <= genRise;
            capLevel_r <= ci.level;
            capVal_r   <= {ci.transpAct, ci.transpPos, ci.stops}; // [R13]
        end else if (commit) begin
            setPend_r <= 1'b0;
            for (int i = 0; i < organ_pkg::N_SFZ; i++) begin
                if (capSfz_r[i]) sfzMem_r[i] <= capVal_r.stops; // [R11]
            end
            for (int i = 0; i < organ_pkg::N_VENT; i++) begin
                if (capVent_r[i]) ventMem_r[i] <= capVal_r.stops; // [R12]
            end
            for (int g = 0; g < organ_pkg::N_GEN; g++) begin
                if (capGen_r[g]) genMem_r[capLevel_r * organ_pkg::N_GEN + g] <= capVal_r; // [R13]
            end
        end else if (!ci.setPiston) begin
            sfzOn_r  <= sfzOn_r ^ sfzRise;
            ventOn_r <= ventOn_r ^ ventRise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Console outputs
    logic [organ_pkg::STEP_W-1:0] stepLamps_r;
    logic [organ_pkg::STOP_W-1:0] stopsOut_r;
    logic [organ_pkg::STOP_W-1:0] genStops_r;
    logic [organ_pkg::TPOS_W-1:0] transpPos_r;
    logic                         transpAct_r;

    // Lamps dark outside the mode; ventils cut wind from their stops
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stepLamps_r <= '0;
            stopsOut_r  <= '0;
            genStops_r  <= '0;
            transpPos_r <= '0;
            transpAct_r <= 1'b0;
        end else begin
            stepLamps_r <= cresMode ? stepNum : '0; // [R3] [R4]
            stopsOut_r  <= (memRd | genStops_r | sfzOr) & ~ventOr; // [R9]
            if (genHit && !ci.setPiston) begin
                genStops_r  <= genMem_r[genSel].stops;
                transpPos_r <= genMem_r[genSel].pos;
                transpAct_r <= genMem_r[genSel].active;
            end
        end
    end

    assign stepLamps = stepLamps_r;
    assign stopsOut  = stopsOut_r;
    assign transpPos = transpPos_r;
    assign transpAct = transpAct_r;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: answers in the second access cycle
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    wire hitStatus = paddr == organ_pkg::OFS_STATUS;
    wire hitLine   = paddr == organ_pkg::OFS_LINE;
    wire hitNote   = paddr == organ_pkg::OFS_NOTE;
    wire hitCombo  = paddr == organ_pkg::OFS_COMBO;
    wire addrHit   = hitStatus | hitLine | hitNote | hitCombo;
    wire apbFirst  = psel & penable & ~pready_r;
    wire wrStrobe  = psel & penable & pready_r & pwrite & ~pslverr_r;

    // Read data selection
    logic [31:0] rdData;
    always_comb begin
        rdData = '0;
        if (hitStatus) begin
            rdData[organ_pkg::ST_MODE]   = cresMode;
            rdData[organ_pkg::ST_PROG]   = progSel_r;
            rdData[organ_pkg::ST_ERASE]  = erState_r != organ_pkg::ER_IDLE;
            rdData[organ_pkg::ST_STEADY] = steady;
            rdData[organ_pkg::ST_STEP +: organ_pkg::STEP_W] = stepNum;
        end
        if (hitLine)  rdData[organ_pkg::N_LINE-1:0] = stopLineOut;
        if (hitCombo) rdData[organ_pkg::STOP_W-1:0] = memRd;
    end

    // Unmapped addresses answer with pslverr and zero data
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= apbFirst;
            pslverr_r <= apbFirst & ~addrHit;
            if (apbFirst) prdata_r <= rdData;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;
    note_driver #(.BOARD_NOTES(BOARD_NOTES)) u_drv (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .noteWr      (wrStrobe & hitNote),
        .noteIdx     (pwdata[organ_pkg::NOTE_W-1:0]),
        .noteOn      (pwdata[organ_pkg::NOTE_ON]),
        .lineWr      (wrStrobe & hitLine),
        .lineData    (pwdata[organ_pkg::N_LINE-1:0]),
        .noteOut     (noteOut),
        .stopLineOut (stopLineOut)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_power_prog;
        $rose(rstn) |-> !progSel_r;
    endproperty
    a_power_prog: assert property (p_power_prog) else $error("program two active after reset"); // [R1]
    property p_toggle;
        selRise |=> (progSel_r != $past(progSel_r));
    endproperty
    a_toggle: assert property (p_toggle) else $error("select piston did not toggle program"); // [R2]
    property p_lamps;
        cresMode |=> (stepLamps == $past(stepIdx) + organ_pkg::STEP_W'(1));
    endproperty
    a_lamps: assert property (p_lamps) else $error("lamps do not show binary step"); // [R3] [R4]
    // Switches read raw, so a broken mode decode shows up here
    property p_store_mode;
        (wrEn && !eraseTick) |-> ci.cresSw && !(ci.clearSw | ci.midiSw | ci.couplerSw) && steady;
    endproperty
    a_store_mode: assert property (p_store_mode) else $error("store outside mode or unsteady"); // [R5] [R7]
    property p_erase_start;
        (erState_r == organ_pkg::ER_ARMED && !ci.clearSw) |=> (erState_r == organ_pkg::ER_RUN) && eraseIdx_r == '0;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase did not start on clear off"); // [R6]
    property p_store_data;
        storeOk |=> (cresMem[$past(wrAddr)] == $past(ci.stops));
    endproperty
    a_store_data: assert property (p_store_data) else $error("stored step differs from stops"); // [R8]
    property p_commit;
        commit |-> (!ci.setPiston && !anyHeld) ##1 !setPend_r;
    endproperty
    a_commit: assert property (p_commit) else $error("set stored before release"); // [R11]
    property p_step_sat;
        stepIdx < organ_pkg::STEP_W'(organ_pkg::N_STEPS);
    endproperty
    a_step_sat: assert property (p_step_sat) else $error("step beyond last"); // [R18]
    c_store: cover property (storeOk);
    c_erase_done: cover property (eraseTick && lastErase);
    c_set_commit: cover property (commit && capGen_r != '0);

endmodule

// file: test/console_model.sv
`timescale 1ns/1ps
module console_model (
    // Clock
    input  wire logic              clk_sys,
    // Console pins
    output organ_pkg::console_in_s consoleIn
);
    ////////////////////////////////////////////////////////////////
    // Pins move after an edge, then rest past the synchroniser
    task automatic put(input organ_pkg::console_in_s v);
        @(posedge clk_sys);
        consoleIn <= v;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // All switches open at power-up
    initial consoleIn = '0;
endmodule

// file: test/crescendo_step_programmer_tb.sv
`timescale 1ns/1ps
module crescendo_step_programmer_tb;
    logic                  clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err, transpAct;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, q;
    logic [5:0]            stepLamps;
    logic [15:0]           stopsOut;
    logic [3:0]            transpPos;
    logic [96:0]           noteOut;
    logic [6:0]            stopLineOut;
    organ_pkg::console_in_s c, consoleIn;
    int                    n_fail, total_checks;

    ////////////////////////////////////////////////////////////////
    // Short counts keep the erase walk to a few hundred cycles
    crescendo_step_programmer #(.ERASE_STEP_CYC(4), .STEADY_CYC(3), .BOARD_NOTES(97)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .consoleIn(consoleIn), .stepLamps(stepLamps), .stopsOut(stopsOut), .transpPos(transpPos),
        .transpAct(transpAct), .noteOut(noteOut), .stopLineOut(stopLineOut));
    console_model con (.clk_sys(clk_sys), .consoleIn(consoleIn)); // Sole console feeds the chamber

    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [96:0] seen, input logic [96:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; hold until pready, bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin n_fail++; stop_test(); end
        repeat (3) @(negedge clk_sys);
    endtask

    // Store button press and release
    task automatic tap();
        c.storeBtn = 1'b1; con.put(c);
        c.storeBtn = 1'b0; con.put(c);
    endtask

    ////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Main sequence
    initial begin
        int k;
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        c = '0; n_fail = 0; total_checks = 0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(1'b0, organ_pkg::OFS_STATUS, 32'h0); chk(q[1], 1'b0);
        apb(1'b0, 12'h010, 32'h0); chk(err, 1'b1);
        apb(1'b1, organ_pkg::OFS_LINE, 32'h55); chk(stopLineOut, 7'h55);
        apb(1'b0, organ_pkg::OFS_LINE, 32'h0); chk(q, 32'h55);
        apb(1'b1, organ_pkg::OFS_NOTE, 32'h100);
        apb(1'b1, organ_pkg::OFS_NOTE, 32'h160);
        apb(1'b1, organ_pkg::OFS_NOTE, 32'h161);
        chk(noteOut, (97'h1 << 96) | 97'h1);
        c.cresSw = 1'b1; c.shoe = 6'h05; con.put(c);
        chk(stepLamps, 6'h06);
        apb(1'b0, organ_pkg::OFS_STATUS, 32'h0); chk({q[13:8], q[0]}, 7'h0D);
        c.shoe = 6'h3F; con.put(c); chk(stepLamps, 6'h3C);
        // Erase the first program, then poll busy with a bound
        c.clearSw = 1'b1; con.put(c); tap(); c.clearSw = 1'b0; con.put(c);
        k = 0;
        do begin apb(1'b0, organ_pkg::OFS_STATUS, 32'h0); k++; end while (q[2] !== 1'b0 && k < 100);
        chk(q[2], 1'b0);
        if (q[2] !== 1'b0) stop_test();
        apb(1'b0, organ_pkg::OFS_COMBO, 32'h0); chk(q, 32'h0);
        c.stops = 16'hA5A5; con.put(c); tap();
        apb(1'b0, organ_pkg::OFS_COMBO, 32'h0); chk(q, 32'hA5A5);
        // A store with another program switch on is refused
        c.midiSw = 1'b1; c.stops = 16'h1111; con.put(c); tap(); c.midiSw = 1'b0; con.put(c);
        apb(1'b0, organ_pkg::OFS_COMBO, 32'h0); chk(q, 32'hA5A5);
        c.cresSw = 1'b0; c.stops = 16'h0; con.put(c);
        chk(stepLamps, 6'h00);
        chk(stopsOut, 16'hA5A5);
        // Sforzando set, then recall on top of the crescendo
        c.stops = 16'h0F00; c.setPiston = 1'b1; con.put(c); c.sfz = 2'b01; con.put(c);
        c.sfz = 2'b00; c.setPiston = 1'b0; c.stops = 16'h0; con.put(c);
        c.sfz = 2'b01; con.put(c); c.sfz = 2'b00; con.put(c);
        chk(stopsOut, 16'hAFA5);
        // Ventil set and engaged cuts its stops; a general keeps the transposer
        c.stops = 16'h0005; c.setPiston = 1'b1; con.put(c); c.ventil = 2'b01; con.put(c);
        c.ventil = 2'b00; c.setPiston = 1'b0; c.stops = 16'h0; con.put(c);
        c.ventil = 2'b01; con.put(c); c.ventil = 2'b00; con.put(c);
        chk(stopsOut, 16'hAFA0);
        c.level = 2'h2; c.transpPos = 4'h9; c.transpAct = 1'b1; c.stops = 16'h0030; c.setPiston = 1'b1; con.put(c);
        c.general = 4'h4; con.put(c); c.general = 4'h0; c.setPiston = 1'b0; c.stops = 16'h0; con.put(c);
        c.transpPos = 4'h0; c.transpAct = 1'b0; c.general = 4'h4; con.put(c); c.general = 4'h0; con.put(c);
        chk(transpPos, 4'h9);
        chk(transpAct, 1'b1);
        chk(stopsOut, 16'hAFB0);
        c.cresSel = 1'b1; con.put(c); c.cresSel = 1'b0; con.put(c);
        apb(1'b0, organ_pkg::OFS_STATUS, 32'h0); chk(q[1], 1'b1);
        stop_test();
    end
endmodule
